/* File: dv/token_ring_mac_profile_test.sv */
/*
 Testbench joining station and ring ends; registers over Avalon-MM.
 Assumes the design package and link interface are compiled first.
*/
`timescale 1ns/1ps
module token_ring_mac_profile_test
	import trmp_pkg::*;
;
	localparam logic [47:0] OWN_ADDR = 48'h400012345678;
	localparam logic [47:0] GRP_ADDR = 48'h800000a5a5a5;
	localparam logic [47:0] SRC_ADDR = 48'h40000000beef;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic irq_o;
	logic [47:0] rx_src_o;
	logic rx_accept_o;
	logic send_i = 1'b0;
	logic [47:0] dest_i = 48'h0;
	logic [12:0] info_len_i = 13'h0;
	logic token_i = 1'b0;
	logic busy_o;
	int n_errors = 0;
	int cmp_count = 0;
	logic [3:0] ra[5] = '{REG_CTRL, REG_STATUS, REG_MASK, REG_GROUP_LO, 4'h2};
	logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, OWN_ADDR[31:0], 32'h0};

	always #10 sys_clk_i = ~sys_clk_i;

	trmp_ring_if u_trmp_ring_if (.sys_clk_i(sys_clk_i));
	trmp_station u_trmp_station (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .my_addr_i(OWN_ADDR),
		.group_addr_i(GRP_ADDR), .tx_dest_i(48'h0), .rx_src_o(rx_src_o),
		.rx_accept_o(rx_accept_o), .ring(u_trmp_ring_if));
	trmp_ring_end u_trmp_ring_end (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .send_i(send_i),
		.dest_i(dest_i), .src_i(SRC_ADDR), .info_len_i(info_len_i), .token_i(token_i),
		.busy_o(busy_o), .heard_data_o(), .heard_valid_o(), .ring(u_trmp_ring_if));
	trmp_link_assertions u_trmp_link_assertions (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.st_data(u_trmp_ring_if.st_data), .st_valid(u_trmp_ring_if.st_valid),
		.st_last(u_trmp_ring_if.st_last), .rg_data(u_trmp_ring_if.rg_data),
		.rg_valid(u_trmp_ring_if.rg_valid), .rg_last(u_trmp_ring_if.rg_last),
		.token(u_trmp_ring_if.token));

	task automatic test_done;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic w;
		int n;
		w = 1'b1;
		n = 0;
		q = 32'h0;
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= d;
		while (w !== 1'b0 && n < 50) begin
			@(posedge sys_clk_i);
			w = avs_waitrequest_o;
			q = avs_readdata_o;
			n++;
		end
		check("waitrequest", w, 1'b0);
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		av_xfer(1'b1, a, d, q);
		@(negedge sys_clk_i);
	endtask

	// Sends one frame from the ring end and reports whether the station accepted it.
	task automatic frame(input logic [47:0] d, input logic [12:0] len, output logic got);
		int n;
		@(posedge sys_clk_i);
		send_i <= 1'b1;
		dest_i <= d;
		info_len_i <= len;
		@(posedge sys_clk_i);
		send_i <= 1'b0;
		got = 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk_i);
			got = got | rx_accept_o;
			n++;
		end while ((busy_o !== 1'b0 || n < 3) && n < 6000);
		check("frame end", busy_o, 1'b0);
		repeat (20) begin
			@(negedge sys_clk_i);
			got = got | rx_accept_o;
		end
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk_i);
		n_errors++;
		test_done();
	end

	initial begin
		logic [31:0] q;
		logic got;
		logic done;
		logic [47:0] da;
		logic [7:0] fb[$];
		int n;
		repeat (16) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		av_wr(4'h2, 32'hffffffff);
		for (int i = 0; i < 5; i++) begin
			av_xfer(1'b0, ra[i], 32'h0, q);
			check("register", q, rv[i]);
		end
		frame(OWN_ADDR, 13'h1, got);
		check("own accept", got, 1'b1);
		check("source", rx_src_o, SRC_ADDR);
		av_xfer(1'b0, REG_STATUS, 32'h0, q);
		check("status", q[1:0], 2'h1);
		check("irq masked", irq_o, 1'b0);
		av_wr(REG_MASK, 32'h1);
		check("irq raised", irq_o, 1'b1);
		av_wr(REG_STATUS, 32'h1);
		check("irq cleared", irq_o, 1'b0);
		frame(OWN_ADDR ^ 48'h010000000000, 13'h5, got);
		check("near miss", got, 1'b0);
		frame(ALL_STATIONS_ADDR, 13'h3, got);
		check("all stations", got, 1'b1);
		frame(GRP_ADDR, 13'h2, got);
		check("group off", got, 1'b0);
		av_wr(REG_CTRL, 32'h2);
		frame(GRP_ADDR, 13'h2, got);
		check("group on", got, 1'b1);
		av_wr(REG_STATUS, 32'h1ff);
		av_wr(REG_CTRL, 32'h1);
		@(posedge sys_clk_i);
		token_i <= 1'b1;
		done = 1'b0;
		n = 0;
		while (!done && n < 20000) begin
			@(negedge sys_clk_i);
			if (u_trmp_ring_if.st_valid === 1'b1) begin
				fb.push_back(u_trmp_ring_if.st_data);
				done = u_trmp_ring_if.st_last;
			end
			n++;
		end
		check("amp sent", done, 1'b1);
		if (done === 1'b1 && fb.size() > 9) begin
			for (int i = 3; i < 9; i++) begin
				da = {da[39:0], fb[i]};
			end
			check("amp start", fb[0], SD_BYTE);
			check("amp priority", fb[1][7:5], AMP_PRIORITY);
			check("amp control", fb[2], FC_MAC_AMP);
			check("amp dest", da, ALL_STATIONS_ADDR);
			check("amp end", fb[fb.size() - 2], ED_BYTE);
		end
		@(posedge sys_clk_i);
		token_i <= 1'b0;
		av_wr(REG_CTRL, 32'h0);
		test_done();
	end
endmodule

/* File: dv/trmp_link_assertions.sv */
/*
 Checker for the byte-wide ring link between the station and ring ends.
 Assumes it is instantiated beside the link interface, on its clock.
*/
`timescale 1ns/1ps
module trmp_link_assertions
	import trmp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] st_data,
	input wire logic st_valid,
	input wire logic st_last,
	input wire logic [7:0] rg_data,
	input wire logic rg_valid,
	input wire logic rg_last,
	input wire logic token
);
	localparam int unsigned BYTE_CYC = CLK_HZ / (RING_BPS / 8);
	logic [13:0] st_idx_q;
	logic [13:0] rg_idx_q;
	logic [7:0] st_prev_q;
	logic [7:0] rg_prev_q;
	logic [7:0] st_ac_q;
	logic [7:0] st_gap_q;
	logic [7:0] rg_gap_q;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_idx_q <= 14'h0;
			st_prev_q <= 8'h0;
			st_ac_q <= 8'h0;
		end else if (st_valid) begin
			st_prev_q <= st_data;
			st_idx_q <= st_last ? 14'h0 : st_idx_q + 14'h1;
			if (st_idx_q == 14'h1) begin
				st_ac_q <= st_data;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rg_idx_q <= 14'h0;
			rg_prev_q <= 8'h0;
		end else if (rg_valid) begin
			rg_prev_q <= rg_data;
			rg_idx_q <= rg_last ? 14'h0 : rg_idx_q + 14'h1;
		end
	end

	// Cycles since the last byte, saturating so a long idle never wraps.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_gap_q <= 8'h0;
			rg_gap_q <= 8'h0;
		end else begin
			st_gap_q <= st_valid ? 8'h1 : st_gap_q + {7'h0, st_gap_q != 8'hff};
			rg_gap_q <= rg_valid ? 8'h1 : rg_gap_q + {7'h0, rg_gap_q != 8'hff};
		end
	end

	a_rg_starts_sd: assert property (rg_valid && rg_idx_q == 14'h0 |-> rg_data == SD_BYTE)
		else $error("ring frame does not open with the start delimiter");
	a_st_starts_sd: assert property (st_valid && st_idx_q == 14'h0 |-> st_data == SD_BYTE)
		else $error("station frame does not open with the start delimiter");
	a_rg_ed_before_fs: assert property (rg_valid && rg_last |-> rg_prev_q == ED_BYTE)
		else $error("ring frame status not preceded by end delimiter");
	a_st_ed_before_fs: assert property (st_valid && st_last |-> st_prev_q == ED_BYTE)
		else $error("station frame status not preceded by end delimiter");
	a_rg_byte_pace: assert property (rg_valid && rg_idx_q != 14'h0 |-> rg_gap_q == BYTE_CYC)
		else $error("ring byte spacing off the line rate");
	a_st_byte_pace: assert property (st_valid && st_idx_q != 14'h0 |-> st_gap_q == BYTE_CYC)
		else $error("station byte spacing off the line rate");
	a_st_amp_priority: assert property (st_valid && st_idx_q == 14'h2 && st_data == FC_MAC_AMP
		|-> st_ac_q[7:5] == AMP_PRIORITY)
		else $error("monitor present frame sent with wrong priority");
	a_st_frame_length: assert property (st_valid && st_last |-> st_idx_q >= 14'd20)
		else $error("station frame shorter than its fixed fields");

	c_st_frame: cover property (st_valid && st_last);
	c_rg_frame: cover property (rg_valid && rg_last);
	c_amp_frame: cover property (st_valid && st_idx_q == 14'h2 && st_data == FC_MAC_AMP);
	c_token: cover property (token && st_valid);
endmodule

/* File: rtl/trmp_pkg.sv */
/*
 Constants and types shared by both ends of the token ring MAC profile link.
 Assumes a single 50 MHz system clock with a synchronous active-high reset.
*/
package trmp_pkg;

	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned RING_BPS = 4000000;
	localparam int unsigned BYTE_CYCLES = CLK_HZ / (RING_BPS / 8);
	localparam int unsigned ADDR_W = 48;
	localparam logic [2:0] AMP_PRIORITY = 3'h7;
	localparam logic [47:0] ALL_STATIONS_ADDR = 48'hc000ffffffff;
	localparam logic [47:0] FUNC_ADDR_MASK = 48'h00007fffffff;
	localparam logic [7:0] SD_BYTE = 8'he6;
	localparam logic [7:0] ED_BYTE = 8'hfe;
	localparam logic [7:0] FC_MAC_AMP = 8'h05;
	localparam logic [7:0] FC_LLC = 8'h40;
	localparam logic [12:0] INFO_MAX = 13'h1149;
	localparam logic [12:0] INFO_MIN = 13'h0001;
	localparam logic [12:0] INFO_SUPPORT = 13'h07d0;

	localparam int unsigned TRR_US = 4000;
	localparam int unsigned THT_US = 8900;
	localparam int unsigned TQP_US = 20000;
	localparam int unsigned TVX_US = 10000;
	localparam int unsigned TNT_US = 2600;
	localparam int unsigned TAM_S = 7;
	localparam int unsigned TSM_S = 15;
	localparam int unsigned TRR_CYC = TRR_US * (CLK_HZ / 1000000);
	localparam int unsigned THT_CYC = THT_US * (CLK_HZ / 1000000);
	localparam int unsigned TQP_CYC = TQP_US * (CLK_HZ / 1000000);
	localparam int unsigned TVX_CYC = TVX_US * (CLK_HZ / 1000000);
	localparam int unsigned TNT_CYC = TNT_US * (CLK_HZ / 1000000);
	localparam int unsigned TAM_CYC = TAM_S * CLK_HZ;
	localparam int unsigned TSM_CYC = TSM_S * CLK_HZ;
	localparam int unsigned NUM_TMR = 7;
	localparam int unsigned TMR_W = 30;

	localparam logic [2:0] TMR_TRR = 3'h0;
	localparam logic [2:0] TMR_THT = 3'h1;
	localparam logic [2:0] TMR_TQP = 3'h2;
	localparam logic [2:0] TMR_TVX = 3'h3;
	localparam logic [2:0] TMR_TNT = 3'h4;
	localparam logic [2:0] TMR_TAM = 3'h5;
	localparam logic [2:0] TMR_TSM = 3'h6;

	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h8;
	localparam logic [3:0] REG_GROUP_LO = 4'hc;

	localparam int unsigned ST_RX_FRAME = 0;
	localparam int unsigned ST_RX_LONG = 1;
	localparam int unsigned ST_TIMER0 = 2;
	localparam int unsigned ST_W = 9;

	typedef enum logic [3:0] {
		TRMP_IDLE, TRMP_SD, TRMP_AC, TRMP_FC, TRMP_DA, TRMP_SA, TRMP_INFO,
		TRMP_FCS, TRMP_ED, TRMP_FS
	} trmp_field_type;

endpackage

/* File: rtl/trmp_ring_end.sv */
/*
 Ring end: stands for the other stations, sends a frame when asked and
 passes the token. Assumes user requests are one-cycle pulses.
*/
`timescale 1ns/1ps
module trmp_ring_end
	import trmp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic send_i,
	input wire logic [47:0] dest_i,
	input wire logic [47:0] src_i,
	input wire logic [12:0] info_len_i,
	input wire logic token_i,
	output logic busy_o,
	output logic [7:0] heard_data_o,
	output logic heard_valid_o,
	trmp_ring_if.ring ring
);

	trmp_field_type st_q;
	logic [12:0] n_q;
	logic [12:0] len_q;
	logic [95:0] addr_q;
	logic [6:0] div_q;
	logic tick;

	assign tick = (div_q == 7'h0);
	assign busy_o = (st_q != TRMP_IDLE);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) div_q <= 7'h0;
		else if (tick) div_q <= 7'(BYTE_CYCLES - 1);
		else div_q <= div_q - 7'h1;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			heard_data_o <= 8'h0;
			heard_valid_o <= 1'b0;
			ring.token <= 1'b0;
		end else begin
			heard_data_o <= ring.st_data;
			heard_valid_o <= ring.st_valid;
			ring.token <= token_i & ~busy_o;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_q <= TRMP_IDLE;
			n_q <= 13'h0;
			len_q <= 13'h0;
			addr_q <= 96'h0;
			ring.rg_data <= 8'h0;
			ring.rg_valid <= 1'b0;
			ring.rg_last <= 1'b0;
		end else begin
			ring.rg_valid <= 1'b0;
			ring.rg_last <= 1'b0;
			if (st_q == TRMP_IDLE && send_i) begin
				st_q <= TRMP_SD;
				len_q <= (info_len_i > INFO_MAX) ? INFO_MAX : info_len_i;
				addr_q <= {dest_i, src_i};
				n_q <= 13'h0;
			end else if (tick && st_q != TRMP_IDLE) begin
				ring.rg_valid <= 1'b1;
				n_q <= n_q + 13'h1;
				case (st_q)
					TRMP_SD: begin
						ring.rg_data <= SD_BYTE;
						st_q <= TRMP_AC;
					end
					TRMP_AC: begin
						ring.rg_data <= 8'h10;
						st_q <= TRMP_FC;
					end
					TRMP_FC: begin
						ring.rg_data <= FC_LLC;
						st_q <= TRMP_DA;
						n_q <= 13'h0;
					end
					TRMP_DA, TRMP_SA: begin
						ring.rg_data <= addr_q[95:88];
						addr_q <= {addr_q[87:0], 8'h00};
						if (n_q == 13'hb) begin
							st_q <= TRMP_INFO;
							n_q <= 13'h0;
						end
					end
					TRMP_INFO: begin
						ring.rg_data <= n_q[7:0];
						if (n_q + 13'h1 >= len_q) begin
							st_q <= TRMP_FCS;
							n_q <= 13'h0;
						end
					end
					TRMP_FCS: begin
						ring.rg_data <= 8'h00;
						if (n_q == 13'h3) st_q <= TRMP_ED;
					end
					TRMP_ED: begin
						ring.rg_data <= ED_BYTE;
						st_q <= TRMP_FS;
					end
					TRMP_FS: begin
						ring.rg_data <= 8'h00;
						ring.rg_last <= 1'b1;
						st_q <= TRMP_IDLE;
					end
					default: st_q <= TRMP_IDLE;
				endcase
			end
		end
	end

endmodule

/* File: rtl/trmp_ring_if.sv */
/*
 Byte-wide ring link between a station MAC and the rest of the ring.
 Assumes both ends share sys_clk_i; one byte moves per valid cycle.
*/
`timescale 1ns/1ps
interface trmp_ring_if (
	input wire logic sys_clk_i
);
	logic [7:0] st_data;
	logic st_valid;
	logic st_last;
	logic [7:0] rg_data;
	logic rg_valid;
	logic rg_last;
	logic token;

	modport station (output st_data, output st_valid, output st_last,
		input rg_data, input rg_valid, input rg_last, input token);
	modport ring (input st_data, input st_valid, input st_last,
		output rg_data, output rg_valid, output rg_last, output token);
endinterface

/* File: rtl/trmp_station.sv */
/*
 Station end: Avalon-MM slave, seven protocol timers, frame sender and receiver.
 Assumes the ring end sends whole frames in field order at byte pace.
*/
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module trmp_station
	import trmp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	input wire logic [47:0] my_addr_i,
	input wire logic [47:0] group_addr_i,
	input wire logic [47:0] tx_dest_i,
	output logic [47:0] rx_src_o,
	output logic rx_accept_o,
	trmp_ring_if.station ring
);

	// ****************************************************
	// Register slave
	// ****************************************************
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] mask_q;
	logic [2:0] ctrl_q;
	logic ack_q;
	logic [ST_W-1:0] ev;
	logic [NUM_TMR-1:0] tmr_exp;
	logic [NUM_TMR-1:0] tmr_rst;
	logic tx_busy;

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) ack_q <= 1'b0;
		else ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ctrl_q <= 3'h0;
			mask_q <= '0;
		end else if (avs_write_i & ack_q) begin
			if (avs_address_i == REG_CTRL) ctrl_q <= avs_writedata_i[2:0];
			if (avs_address_i == REG_MASK) mask_q <= avs_writedata_i[ST_W-1:0];
		end
	end

	// Set wins over a write-one clear in the same cycle.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) status_q <= '0;
		else if (avs_write_i & ack_q & (avs_address_i == REG_STATUS))
			status_q <= (status_q & ~avs_writedata_i[ST_W-1:0]) | ev;
		else status_q <= status_q | ev;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) avs_readdata_o <= 32'h0;
		else if (avs_read_i & ~ack_q) begin
			case (avs_address_i)
				REG_CTRL: avs_readdata_o <= {28'h0, tx_busy, ctrl_q};
				REG_STATUS: avs_readdata_o <= {23'h0, status_q};
				REG_MASK: avs_readdata_o <= {23'h0, mask_q};
				REG_GROUP_LO: avs_readdata_o <= my_addr_i[31:0];
				default: avs_readdata_o <= 32'h0;
			endcase
		end
	end

	assign irq_o = |(status_q & mask_q);

	// ****************************************************
	// Protocol timers
	// ****************************************************
	function automatic logic [TMR_W-1:0] tmr_len(input int unsigned idx);
		case (idx)
			0: tmr_len = TMR_W'(TRR_CYC);
			1: tmr_len = TMR_W'(THT_CYC);
			2: tmr_len = TMR_W'(TQP_CYC);
			3: tmr_len = TMR_W'(TVX_CYC);
			4: tmr_len = TMR_W'(TNT_CYC);
			5: tmr_len = TMR_W'(TAM_CYC);
			default: tmr_len = TMR_W'(TSM_CYC);
		endcase
	endfunction

	for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
		logic [TMR_W-1:0] cnt_q;
		logic run_q;
		always_ff @(posedge sys_clk_i) begin
			if (reset_i) begin
				cnt_q <= '0;
				run_q <= 1'b0;
			end else if (tmr_rst[g]) begin
				cnt_q <= tmr_len(g) - TMR_W'(1);
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q == '0) run_q <= 1'b0;
				else cnt_q <= cnt_q - TMR_W'(1);
			end
		end
		assign tmr_exp[g] = run_q & (cnt_q == '0);
	end

	// ****************************************************
	// Receiver
	// ****************************************************
	trmp_field_type rx_st_q;
	logic [3:0] rx_n_q;
	logic [12:0] rx_len_q;
	logic [47:0] rx_da_q;
	logic rx_long_q;
	logic rx_end;
	logic rx_match;

	function automatic logic addr_hit(input logic [47:0] da, input logic [47:0] me,
		input logic [47:0] grp, input logic grp_en);
		addr_hit = (da == me) || (da == ALL_STATIONS_ADDR)
			|| (grp_en && da == grp)
			|| (da[47:31] == 17'h18001 && |(da[30:0] & me[30:0]));
	endfunction

	assign rx_end = ring.rg_valid & ring.rg_last;
	assign rx_match = addr_hit(rx_da_q, my_addr_i, group_addr_i, ctrl_q[1]);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rx_st_q <= TRMP_IDLE;
			rx_n_q <= 4'h0;
			rx_len_q <= 13'h0;
			rx_da_q <= 48'h0;
			rx_src_o <= 48'h0;
			rx_long_q <= 1'b0;
		end else if (ring.rg_valid) begin
			rx_n_q <= rx_n_q + 4'h1;
			case (rx_st_q)
				TRMP_IDLE: begin
					rx_st_q <= (ring.rg_data == SD_BYTE) ? TRMP_AC : TRMP_IDLE;
					rx_len_q <= 13'h0;
					rx_long_q <= 1'b0;
				end
				TRMP_AC: rx_st_q <= TRMP_FC;
				TRMP_FC: begin
					rx_st_q <= TRMP_DA;
					rx_n_q <= 4'h0;
				end
				TRMP_DA: begin
					rx_da_q <= {rx_da_q[39:0], ring.rg_data};
					if (rx_n_q == 4'h5) begin
						rx_st_q <= TRMP_SA;
						rx_n_q <= 4'h0;
					end
				end
				TRMP_SA: begin
					rx_src_o <= {rx_src_o[39:0], ring.rg_data};
					if (rx_n_q == 4'h5) rx_st_q <= TRMP_INFO;
				end
				TRMP_INFO: begin
					if (rx_len_q != 13'h1fff) rx_len_q <= rx_len_q + 13'h1;
					if (rx_len_q >= INFO_MAX + 13'h5) rx_long_q <= 1'b1;
				end
				default: rx_st_q <= TRMP_IDLE;
			endcase
			if (ring.rg_last) rx_st_q <= TRMP_IDLE;
		end
	end

	// At the status byte the count holds the info bytes plus FCS and ED (5 bytes).
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) rx_accept_o <= 1'b0;
		else rx_accept_o <= rx_end && rx_st_q == TRMP_INFO && rx_match && !rx_long_q
			&& rx_len_q >= INFO_MIN + 13'h5;
	end

	// ****************************************************
	// Transmitter
	// ****************************************************
	trmp_field_type tx_st_q;
	logic [3:0] tx_n_q;
	logic [6:0] tx_div_q;
	logic [7:0] tx_data;
	logic tick;
	logic tht_run_q;

	assign tick = (tx_div_q == 7'h0);
	assign tx_busy = (tx_st_q != TRMP_IDLE);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) tx_div_q <= 7'h0;
		else if (tick) tx_div_q <= 7'(BYTE_CYCLES - 1);
		else tx_div_q <= tx_div_q - 7'h1;
	end

	always_comb begin
		case (tx_st_q)
			TRMP_SD: tx_data = SD_BYTE;
			TRMP_AC: tx_data = {AMP_PRIORITY, 5'h10};
			TRMP_FC: tx_data = FC_MAC_AMP;
			TRMP_DA: tx_data = ALL_STATIONS_ADDR[47 - 8 * tx_n_q -: 8];
			TRMP_SA: tx_data = my_addr_i[47 - 8 * tx_n_q -: 8];
			TRMP_INFO: tx_data = 8'h00;
			TRMP_FCS: tx_data = 8'h00;
			TRMP_ED: tx_data = ED_BYTE;
			TRMP_FS: tx_data = 8'h00;
			default: tx_data = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			tx_st_q <= TRMP_IDLE;
			tx_n_q <= 4'h0;
			ring.st_data <= 8'h0;
			ring.st_valid <= 1'b0;
			ring.st_last <= 1'b0;
		end else begin
			ring.st_valid <= tick & tx_busy;
			ring.st_data <= tx_data;
			ring.st_last <= tick & (tx_st_q == TRMP_FS);
			if (tick) begin
				tx_n_q <= tx_n_q + 4'h1;
				case (tx_st_q)
					TRMP_IDLE: if (ctrl_q[0] && ring.token && !tmr_exp[TMR_THT]
						&& tht_run_q) tx_st_q <= TRMP_SD;
					TRMP_SD: tx_st_q <= TRMP_AC;
					TRMP_AC: tx_st_q <= TRMP_FC;
					TRMP_FC: begin
						tx_st_q <= TRMP_DA;
						tx_n_q <= 4'h0;
					end
					TRMP_DA: if (tx_n_q == 4'h5) begin
						tx_st_q <= TRMP_SA;
						tx_n_q <= 4'h0;
					end
					TRMP_SA: if (tx_n_q == 4'h5) begin
						tx_st_q <= TRMP_INFO;
						tx_n_q <= 4'h0;
					end
					TRMP_INFO: if (tx_n_q == 4'h1) begin
						tx_st_q <= TRMP_FCS;
						tx_n_q <= 4'h0;
					end
					TRMP_FCS: if (tx_n_q == 4'h3) tx_st_q <= TRMP_ED;
					TRMP_ED: tx_st_q <= TRMP_FS;
					default: tx_st_q <= TRMP_IDLE;
				endcase
				if (tx_st_q == TRMP_IDLE) tx_n_q <= 4'h0;
			end
		end
	end

	// Token hold window opens when the token arrives and closes on expiry.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) tht_run_q <= 1'b0;
		else if (tmr_exp[TMR_THT]) tht_run_q <= 1'b0;
		else if (ring.token && !tht_run_q && !tx_busy) tht_run_q <= 1'b1;
		else if (!ring.token && !tx_busy) tht_run_q <= 1'b0;
	end

	// ****************************************************
	// Timer restarts and events
	// ****************************************************
	always_comb begin
		tmr_rst = '0;
		tmr_rst[TMR_THT] = ring.token & ~tht_run_q & ~tx_busy;
		tmr_rst[TMR_TRR] = ring.st_last | tmr_exp[TMR_TRR];
		tmr_rst[TMR_TVX] = rx_end | tmr_exp[TMR_TVX];
		tmr_rst[TMR_TNT] = ring.token | tmr_exp[TMR_TNT];
		tmr_rst[TMR_TQP] = (ctrl_q[0] & ~tx_busy & ~tmr_exp[TMR_TQP]) == 1'b0 ? 1'b0
			: ~(g_tmr[TMR_TQP].run_q);
		tmr_rst[TMR_TAM] = ctrl_q[2] & ~g_tmr[TMR_TAM].run_q;
		tmr_rst[TMR_TSM] = ~ctrl_q[2] & ~g_tmr[TMR_TSM].run_q;
		ev = '0;
		ev[ST_RX_FRAME] = rx_accept_o;
		ev[ST_RX_LONG] = rx_end & rx_long_q;
		ev[ST_W-1:ST_TIMER0] = tmr_exp;
	end

endmodule
